// *** pkg/scims_cfg.svh ***
// Purpose: Constants of the segment-driven two-wire master block.
// Assumes: APB with 32-bit data; each register index sits at 4 x index.
// Notes:   Register offsets are indices, not byte addresses.
//
// Overview of operation
// - Software reaches a one-byte transmit and a one-byte receive buffer.
// - Start, restart and stop requests clear themselves when done.
// - Load data, set send; device sends, clears request, sets tx done.
// - Receive request clocks one byte in, clears itself, sets rx done flag.
// - Status records whether the slave acknowledged the last sent byte.
// - Command done rising after start or stop raises an interrupt event.
// - A sent byte answered by not-acknowledge raises an interrupt event.
// - Transmit done flag rising raises an interrupt event.
// - Receive done flag rising raises an interrupt event.
// - Byte arriving with receive buffer full is lost; overrun interrupts.
// - Sending from an empty transmit buffer sets underrun and interrupts.
// - Interrupt reaches the processor only if block and top masks are set.
// - Mode field: 0 and 1 disable, 2 selects SPI, 3 selects two-wire mode.
// - Each data register write pushes the byte into the transmit buffer.
// - Each read of the data register pulls and removes the received byte.
// - Rate is 24 MHz over 2 times (linear plus one) times 2 to exponent.
// - Receive segment ends with acknowledge or not per the select bit.
`ifndef SCIMS_CFG_SVH
`define SCIMS_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices and reset values
// ----------------------------------------------------------------------------
`define SCIMS_DATA_IDX 17'h0441e
`define SCIMS_MODE_IDX 17'h0442a
`define SCIMS_RLIN_IDX 17'h04430
`define SCIMS_REXP_IDX 17'h04432
`define SCIMS_CTRL1_IDX 17'h04438
`define SCIMS_CTRL2_IDX 17'h0443a
`define SCIMS_STAT_IDX 17'h0443c
`define SCIMS_IMASK_IDX 17'h0443e
`define SCIMS_REG_RESET 16'h0000

// ----------------------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------------------
`define SCIMS_REQ_STOP 3
`define SCIMS_REQ_START 2
`define SCIMS_REQ_SEND 1
`define SCIMS_REQ_RECV_B 0
`define SCIMS_MODE_SPI 2'h2
`define SCIMS_MODE_I2C 2'h3
`define SCIMS_COND_LAST 5'h02
`define SCIMS_ACK_STEP 5'h0f
`define SCIMS_BYTE_LAST 5'h11
`define SCIMS_REF_MHZ 24

`endif

// *** pkg/scims_pkg.sv ***
// Purpose: Types shared by the segment-driven two-wire master.
// Assumes: Constants come from scims_cfg.svh.
// Notes:   All state of each module is one packed struct.
package scims_pkg;

  // --------------------------------------------------------------------------
  // Segment engine states, Gray coded along idle-start-send-recv-stop
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SCIMS_IDLE = 3'h0,
    SCIMS_START = 3'h1,
    SCIMS_SEND = 3'h3,
    SCIMS_RECV = 3'h2,
    SCIMS_STOP = 3'h6
  } scims_seg_t;

  // Request bits: [3] stop, [2] start, [1] send, [0] receive.
  typedef struct packed {
    scims_seg_t seg;
    logic [4:0] step;
    logic [7:0] shift;
    logic [1:0] mode;
    logic [3:0] lin;
    logic [3:0] expo;
    logic [3:0] req;
    logic ack_sel;
    logic [7:0] tx_byte;
    logic tx_full;
    logic [7:0] rx_byte;
    logic rx_full;
    logic cmd_done;
    logic tx_done;
    logic rx_done;
    logic nack;
    logic rx_ovf;
    logic tx_udr;
    logic [5:0] irq_mask;
    logic scl_low;
    logic sda_low;
    logic pin_lvl;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [2:0] ref_sync;
    logic scl_lvl;
    logic sda_lvl;
    logic ref_lvl;
    logic ref_edge;
  } scims_state_t;

  typedef struct packed {
    logic [19:0] cnt;
    logic tick;
  } scims_div_t;

  // Byte address of a register index.
  function automatic logic [16:0] scims_adr(input logic [16:0] idx);
    return {idx[14:0], 2'b00};
  endfunction : scims_adr

endpackage : scims_pkg

// *** rtl/scims_rate_div.sv ***
// Purpose: Half-bit tick generator from the 24 MHz reference edges.
// Assumes: ref_edge_in is a one-cycle pulse per reference rising edge.
// Notes:   Counter restarts whenever run_in is low.
`timescale 1ns/1ns
`include "scims_cfg.svh"
module scims_rate_div
  import scims_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic ref_edge_in,
  input wire logic run_in,
  input wire logic [3:0] lin_in,
  input wire logic [3:0] expo_in,
  output logic tick_out
);

  scims_div_t r_reg;
  scims_div_t r_next;
  logic [19:0] term;

  // ---------------------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------------------
  // Half period is (lin+1)*2^expo reference cycles, giving the full rate.
  assign term = 20'(({15'h0000, 5'(lin_in) + 5'h01} << expo_in) - 20'h00001);

  always_comb begin : div_next
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (!run_in) begin
      r_next.cnt = 20'h00000;
    end else if (ref_edge_in) begin
      if (r_reg.cnt >= term) begin
        r_next.cnt = 20'h00000;
        r_next.tick = 1'b1;
      end else begin
        r_next.cnt = r_reg.cnt + 20'h00001;
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin : div_regs
    if (!rst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick_out = r_reg.tick;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  rate_term_a: assert property (@(posedge clk_sys_in)
    disable iff (!rst_n_in)
    run_in && ref_edge_in && r_reg.cnt == term |=> tick_out && r_reg.cnt == 0)
    else $error("divider missed its terminal count");

endmodule : scims_rate_div

// *** rtl/scims_top.sv ***
// Purpose: Segment-driven two-wire master with APB register access.
// Assumes: 100 MHz system clock; 24 MHz reference arrives as a pin.
// Notes:   SPI mode only selects away from two-wire; its engine is elsewhere.
`timescale 1ns/1ns
`include "scims_cfg.svh"
module scims_top
  import scims_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [16:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic ref_clk_24_in,
  input wire logic top_irq_en_in,
  output logic irq_event_out
);

  scims_state_t r_reg;
  scims_state_t r_next;
  logic tick;
  logic acc;
  logic xfer;
  logic rd_xfer;
  logic wr_xfer;
  logic i2c_on;
  logic fin_send;
  logic fin_recv;
  logic fin_cond;
  logic launch;

  // ---------------------------------------------------------------------------
  // Shared strobes
  // ---------------------------------------------------------------------------
  // A transfer completes on the edge where the registered ready is seen.
  assign acc = psel_in & penable_in;
  assign xfer = acc & r_reg.pready;
  assign rd_xfer = xfer & ~pwrite_in;
  assign wr_xfer = xfer & pwrite_in;
  assign i2c_on = r_reg.mode == `SCIMS_MODE_I2C;
  assign launch = i2c_on && r_reg.seg == SCIMS_IDLE && r_reg.req != 4'h0;
  assign fin_cond = tick && r_reg.step == `SCIMS_COND_LAST &&
    (r_reg.seg == SCIMS_START || r_reg.seg == SCIMS_STOP);
  assign fin_send = tick && r_reg.seg == SCIMS_SEND &&
    r_reg.step == `SCIMS_BYTE_LAST;
  assign fin_recv = tick && r_reg.seg == SCIMS_RECV &&
    r_reg.step == `SCIMS_BYTE_LAST;

  // Bit timing; it only runs while a segment is on the bus.
  scims_rate_div u_div (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .ref_edge_in(r_reg.ref_edge),
    .run_in(r_reg.seg != SCIMS_IDLE),
    .lin_in(r_reg.lin),
    .expo_in(r_reg.expo),
    .tick_out(tick)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Order matters: software clears come first so hardware sets win.
  always_comb begin : next_state
    logic [31:0] rdata;
    logic [7:0] sel;
    logic [5:0] ev;
    logic [7:0] sh;
    rdata = 32'h00000000;
    sel = 8'h00;
    ev = 6'h00;
    sh = {r_reg.shift[6:0], r_reg.sda_lvl};
    r_next = r_reg;
    r_next.pready = 1'b0;
    r_next.pslverr = 1'b0;
    r_next.ref_edge = 1'b0;
    r_next.pin_lvl = 1'b0;

    // Pins pass three flops; a level counts once stages two and three agree.
    r_next.scl_sync = {r_reg.scl_sync[1:0], scl_in};
    r_next.sda_sync = {r_reg.sda_sync[1:0], sda_in};
    r_next.ref_sync = {r_reg.ref_sync[1:0], ref_clk_24_in};
    if (r_reg.scl_sync[2] == r_reg.scl_sync[1]) begin
      r_next.scl_lvl = r_reg.scl_sync[2];
    end
    if (r_reg.sda_sync[2] == r_reg.sda_sync[1]) begin
      r_next.sda_lvl = r_reg.sda_sync[2];
    end
    if (r_reg.ref_sync[2] == r_reg.ref_sync[1]) begin
      r_next.ref_lvl = r_reg.ref_sync[2];
      r_next.ref_edge = r_reg.ref_sync[2] & ~r_reg.ref_lvl;
    end

    // Address decode; unmapped addresses answer with an error.
    if (paddr_in == scims_adr(`SCIMS_DATA_IDX)) begin
      sel[0] = 1'b1;
      rdata = {24'h000000, r_reg.rx_byte};
    end else if (paddr_in == scims_adr(`SCIMS_MODE_IDX)) begin
      sel[1] = 1'b1;
      rdata = {30'h00000000, r_reg.mode};
    end else if (paddr_in == scims_adr(`SCIMS_RLIN_IDX)) begin
      sel[2] = 1'b1;
      rdata = {28'h0000000, r_reg.lin};
    end else if (paddr_in == scims_adr(`SCIMS_REXP_IDX)) begin
      sel[3] = 1'b1;
      rdata = {28'h0000000, r_reg.expo};
    end else if (paddr_in == scims_adr(`SCIMS_CTRL1_IDX)) begin
      sel[4] = 1'b1;
      rdata = {28'h0000000, r_reg.req};
    end else if (paddr_in == scims_adr(`SCIMS_CTRL2_IDX)) begin
      sel[5] = 1'b1;
      rdata = {31'h00000000, r_reg.ack_sel};
    end else if (paddr_in == scims_adr(`SCIMS_STAT_IDX)) begin
      sel[6] = 1'b1;
      rdata = {23'h000000, r_reg.seg != SCIMS_IDLE, r_reg.tx_full,
        r_reg.rx_full, r_reg.tx_udr, r_reg.rx_ovf, r_reg.nack,
        r_reg.rx_done, r_reg.tx_done, r_reg.cmd_done};
    end else if (paddr_in == scims_adr(`SCIMS_IMASK_IDX)) begin
      sel[7] = 1'b1;
      rdata = {26'h0000000, r_reg.irq_mask};
    end

    // One wait state: ready and read data rise together, one cycle in.
    if (acc && !r_reg.pready) begin
      r_next.pready = 1'b1;
      r_next.prdata = rdata;
      r_next.pslverr = ~|sel;
    end

    // Register writes take effect only on the completing edge.
    if (wr_xfer) begin
      if (sel[0]) begin
        r_next.tx_byte = pwdata_in[7:0];
        r_next.tx_full = 1'b1;
      end
      if (sel[1]) begin
        r_next.mode = pwdata_in[1:0];
      end
      if (sel[2]) begin
        r_next.lin = pwdata_in[3:0];
      end
      if (sel[3]) begin
        r_next.expo = pwdata_in[3:0];
      end
      if (sel[4] && r_reg.req == 4'h0) begin
        r_next.req = pwdata_in[3:0];
      end
      if (sel[5]) begin
        r_next.ack_sel = pwdata_in[0];
      end
      if (sel[6]) begin
        r_next.cmd_done = r_reg.cmd_done & ~pwdata_in[0];
        r_next.tx_done = r_reg.tx_done & ~pwdata_in[1];
        r_next.rx_done = r_reg.rx_done & ~pwdata_in[2];
        r_next.nack = r_reg.nack & ~pwdata_in[3];
        r_next.rx_ovf = r_reg.rx_ovf & ~pwdata_in[4];
        r_next.tx_udr = r_reg.tx_udr & ~pwdata_in[5];
      end
      if (sel[7]) begin
        r_next.irq_mask = pwdata_in[5:0];
      end
    end
    if (rd_xfer && sel[0]) begin
      r_next.rx_full = 1'b0;
    end

    // Segment engine. Outside two-wire mode the pins are released.
    if (!i2c_on) begin
      r_next.seg = SCIMS_IDLE;
      r_next.req = 4'h0;
      r_next.scl_low = 1'b0;
      r_next.sda_low = 1'b0;
    end else begin
      case (r_reg.seg)
        SCIMS_IDLE: begin
          r_next.step = 5'h00;
          if (r_reg.req[`SCIMS_REQ_START] &&
            r_reg.req[`SCIMS_REQ_SEND]) begin
            r_next.req = 4'h0;
          end else if (r_reg.req[`SCIMS_REQ_START]) begin
            r_next.seg = SCIMS_START;
            r_next.cmd_done = 1'b0;
            r_next.scl_low = 1'b1;
            r_next.sda_low = 1'b0;
          end else if (r_reg.req[`SCIMS_REQ_SEND]) begin
            r_next.seg = SCIMS_SEND;
            r_next.tx_done = 1'b0;
            r_next.shift = r_reg.tx_byte;
            r_next.tx_full = 1'b0;
            r_next.scl_low = 1'b1;
            r_next.sda_low = ~r_reg.tx_byte[7];
            if (!r_reg.tx_full) begin
              r_next.tx_udr = 1'b1;
              ev[5] = 1'b1;
            end
          end else if (r_reg.req[`SCIMS_REQ_RECV_B]) begin
            r_next.seg = SCIMS_RECV;
            r_next.rx_done = 1'b0;
            r_next.scl_low = 1'b1;
            r_next.sda_low = 1'b0;
          end else if (r_reg.req[`SCIMS_REQ_STOP]) begin
            r_next.seg = SCIMS_STOP;
            r_next.cmd_done = 1'b0;
            r_next.scl_low = 1'b1;
            r_next.sda_low = 1'b1;
          end
        end
        SCIMS_START, SCIMS_STOP: begin
          if (tick) begin
            r_next.step = r_reg.step + 5'h01;
            if (r_reg.step == 5'h00) begin
              r_next.scl_low = 1'b0;
            end else if (r_reg.step == 5'h01) begin
              // Data moves while the clock is high: start pulls, stop frees.
              r_next.sda_low = r_reg.seg == SCIMS_START;
            end else begin
              r_next.seg = SCIMS_IDLE;
              r_next.cmd_done = 1'b1;
              if (r_reg.seg == SCIMS_START) begin
                r_next.scl_low = 1'b1;
                r_next.req[`SCIMS_REQ_START] = 1'b0;
              end else begin
                r_next.req[`SCIMS_REQ_STOP] = 1'b0;
              end
            end
          end
        end
        default: begin
          // Even steps hold the clock low, odd steps hold it high.
          if (tick) begin
            r_next.step = r_reg.step + 5'h01;
            if (!r_reg.step[0]) begin
              r_next.scl_low = 1'b0;
            end else if (r_reg.step != `SCIMS_BYTE_LAST) begin
              r_next.scl_low = 1'b1;
              r_next.shift = sh;
              if (r_reg.step == `SCIMS_ACK_STEP) begin
                r_next.sda_low = (r_reg.seg == SCIMS_RECV) &
                  r_reg.ack_sel;
              end else begin
                r_next.sda_low = (r_reg.seg == SCIMS_SEND) & ~sh[7];
              end
            end else begin
              r_next.seg = SCIMS_IDLE;
              r_next.scl_low = 1'b1;
              r_next.sda_low = 1'b0;
              if (r_reg.seg == SCIMS_SEND) begin
                r_next.req[`SCIMS_REQ_SEND] = 1'b0;
                r_next.tx_done = 1'b1;
                r_next.nack = r_reg.sda_lvl;
                ev[1] = r_reg.sda_lvl;
              end else begin
                r_next.req[`SCIMS_REQ_RECV_B] = 1'b0;
                r_next.rx_done = 1'b1;
                if (r_next.rx_full) begin
                  r_next.rx_ovf = 1'b1;
                  ev[4] = 1'b1;
                end else begin
                  r_next.rx_byte = r_reg.shift;
                  r_next.rx_full = 1'b1;
                end
              end
            end
          end
        end
      endcase
    end

    // Done flags interrupt on their rising edge; both masks must agree.
    ev[0] = r_next.cmd_done & ~r_reg.cmd_done;
    ev[2] = r_next.tx_done & ~r_reg.tx_done;
    ev[3] = r_next.rx_done & ~r_reg.rx_done;
    r_next.irq = top_irq_en_in & |(ev & r_reg.irq_mask);
  end

  // Registers the whole block state.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin : state_regs
    if (!rst_n_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs, all from flops
  // ---------------------------------------------------------------------------
  assign prdata_out = r_reg.prdata;
  assign pready_out = r_reg.pready;
  assign pslverr_out = r_reg.pslverr;
  assign scl_out = r_reg.pin_lvl;
  assign scl_oe_out = r_reg.scl_low;
  assign sda_out = r_reg.pin_lvl;
  assign sda_oe_out = r_reg.sda_low;
  assign irq_event_out = r_reg.irq;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  cond_autoclr_a: assert property (fin_cond |=>
    !(r_reg.req[`SCIMS_REQ_START] && $past(r_reg.seg) == SCIMS_START) &&
    !(r_reg.req[`SCIMS_REQ_STOP] && $past(r_reg.seg) == SCIMS_STOP) &&
    r_reg.cmd_done && r_reg.seg == SCIMS_IDLE)
    else $error("condition request did not complete");
  send_done_a: assert property (fin_send |=>
    !r_reg.req[`SCIMS_REQ_SEND] && r_reg.tx_done)
    else $error("send did not finish cleanly");
  recv_done_a: assert property (fin_recv |=>
    !r_reg.req[`SCIMS_REQ_RECV_B] && r_reg.rx_done && r_reg.rx_full)
    else $error("receive did not finish cleanly");
  nack_rec_a: assert property (fin_send |=>
    r_reg.nack == $past(r_reg.sda_lvl))
    else $error("ack status not recorded");
  irq_gate_a: assert property (irq_event_out |->
    $past(top_irq_en_in) && $past(r_reg.irq_mask) != 6'h00)
    else $error("interrupt passed a closed mask");
  txfin_irq_a: assert property ((fin_send && r_reg.irq_mask[2] &&
    top_irq_en_in) |=> irq_event_out)
    else $error("transmit done gave no interrupt");
  mode_gate_a: assert property (!i2c_on |=>
    r_reg.seg == SCIMS_IDLE && !scl_oe_out && !sda_oe_out)
    else $error("engine active outside two-wire mode");
  data_push_a: assert property (wr_xfer &&
    paddr_in == scims_adr(`SCIMS_DATA_IDX) |=>
    r_reg.tx_full && r_reg.tx_byte == $past(pwdata_in[7:0]))
    else $error("data write did not fill transmit buffer");
  data_pop_a: assert property (rd_xfer && !fin_recv &&
    paddr_in == scims_adr(`SCIMS_DATA_IDX) |=> !r_reg.rx_full)
    else $error("data read did not empty receive buffer");
  ovf_flag_a: assert property (fin_recv && r_reg.rx_full &&
    !rd_xfer |=> r_reg.rx_ovf && r_reg.rx_byte == $past(r_reg.rx_byte))
    else $error("overrun not flagged or byte overwritten");
  udr_flag_a: assert property (launch && r_reg.req == 4'h2 &&
    !r_reg.tx_full |=> r_reg.tx_udr)
    else $error("underrun not flagged");
  ack_drive_a: assert property (r_reg.seg == SCIMS_RECV &&
    r_reg.step == 5'h10 |-> sda_oe_out == r_reg.ack_sel)
    else $error("wrong acknowledge driven");
  illegal_a: assert property (launch && r_reg.req[2:1] == 2'b11 |=>
    r_reg.seg == SCIMS_IDLE && r_reg.req == 4'h0)
    else $error("illegal request pair started a segment");

  start_seen_c: cover property (fin_cond && r_reg.seg == SCIMS_START);
  nack_seen_c: cover property (fin_send && r_reg.sda_lvl);
  ovf_seen_c: cover property (fin_recv && r_reg.rx_full);
  irq_seen_c: cover property (irq_event_out);

endmodule : scims_top

// *** bench/scims_slave_model.sv ***
// Purpose: Behavioural two-wire slave facing the segment master.
// Assumes: Open-drain wires with pull-ups are resolved by the bench.
// Notes:   Bit slots are counted from the fall that ends a start.
`timescale 1ns/1ns
module scims_slave_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic rd_in,
  input wire logic ack_en_in,
  input wire logic [7:0] rbyte_in,
  output logic pull_out,
  output logic [7:0] got_out,
  output logic ack_out,
  output int edges_out
);
  // --------------------------------------------------------------------
  // Slot tracking
  // --------------------------------------------------------------------
  int cnt = 9;
  initial edges_out = 0;
  // A start restarts the count; -1 absorbs the fall that ends the start.
  always @(negedge sda_in) if (scl_in) cnt = -1;
  always @(negedge scl_in) begin
    edges_out++;
    cnt = (cnt >= 8) ? 0 : cnt + 1;
  end
  // Data is taken while the clock is high, as a real slave would.
  always @(posedge scl_in) begin
    if (cnt >= 0 && cnt < 8) got_out = {got_out[6:0], sda_in};
    if (cnt == 8) ack_out = sda_in;
  end
  // The slave only pulls in its own slots, so a stop is blocked only while rd_in is high and rbyte_in[7] is 0.
  assign pull_out = rd_in ? (cnt >= 0 && cnt < 8 && !rbyte_in[7 - cnt])
                          : (cnt == 8 && ack_en_in);
endmodule : scims_slave_model

// *** bench/scims_top_tb.sv ***
// Purpose: Self-checking bench of the two-wire segment master.
// Assumes: APB tasks drive the registers; slave model on the wires.
// Notes:   LIN=3 EXP=0 keeps a byte near three hundred clocks.
`timescale 1ns/1ns
`include "scims_cfg.svh"
module scims_top_tb;
  logic clk_sys_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0;
  logic top_en = 1, ref_clk = 0, rd = 0, ack_en = 1;
  logic [16:0] padr = 17'h0;
  logic [31:0] pwd = 32'h0, prd;
  logic pready, pslverr, scl_oe, sda_oe, pull, ackb, irq;
  logic [7:0] rbyte = 8'h00, got;
  int edges, fails = 0, check_count = 0, n_irq = 0, hi_ns;
  time t_up;
  wire scl_w = ~scl_oe;
  wire sda_w = ~(sda_oe | pull);
  initial forever #5 clk_sys_in = ~clk_sys_in;
  // Reference near 24 MHz, unrelated in phase to the system clock.
  initial forever #21 ref_clk = ~ref_clk;
  always @(posedge clk_sys_in) if (irq === 1'b1) n_irq++;
  always @(posedge scl_w) t_up = $time;
  always @(negedge scl_w) hi_ns = int'($time - t_up);
  scims_top i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(pready),
    .pslverr_out(pslverr), .scl_in(scl_w), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe),
    .ref_clk_24_in(ref_clk), .top_irq_en_in(top_en), .irq_event_out(irq));
  scims_slave_model i_slv (.scl_in(scl_w), .sda_in(sda_w), .rd_in(rd),
    .ack_en_in(ack_en), .rbyte_in(rbyte), .pull_out(pull), .got_out(got),
    .ack_out(ackb), .edges_out(edges));
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // Request is held until the edge at which pready is sampled high.
  task automatic apb(input logic w, input logic [16:0] i,
      input logic [31:0] wd, output logic [31:0] r, output logic er);
    int n;
    @(posedge clk_sys_in);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    padr <= {i[14:0], 2'b00};
    pwd <= wd;
    @(posedge clk_sys_in);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up();
    end
    r = prd;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic wr(input logic [16:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, i, d, r, e);
  endtask : wr
  task automatic rdc(input string nm, input logic [16:0] i,
      input logic [31:0] m, x);
    logic [31:0] r;
    logic e;
    apb(0, i, 32'h0, r, e);
    chk(nm, x, r & m);
  endtask : rdc
  // Launch one segment, wait for the request to clear, judge flags.
  task automatic seg(input logic [3:0] q, input logic [5:0] st);
    logic [31:0] r;
    logic e;
    int n;
    wr(`SCIMS_STAT_IDX, 32'h3f);
    wr(`SCIMS_CTRL1_IDX, {28'h0, q});
    r = 32'h1;
    for (n = 0; n < 200 && r[3:0] !== 4'h0; n++)
      apb(0, `SCIMS_CTRL1_IDX, 32'h0, r, e);
    chk("request clear", 32'h1, {31'h0, n < 200});
    if (n == 200) wrap_up();
    rdc("status", `SCIMS_STAT_IDX, 32'h3f, {26'h0, st});
  endtask : seg
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rdc("mode", `SCIMS_MODE_IDX, 32'hffffffff, 32'h0);
    rdc("rate exp", `SCIMS_REXP_IDX, 32'hffffffff, 32'h0);
    apb(0, 17'h00004, 32'h0, r, e);
    chk("unmapped", 32'h1, {31'h0, e});
    wr(`SCIMS_RLIN_IDX, 32'h3);
    rdc("rate lin", `SCIMS_RLIN_IDX, 32'hffffffff, 32'h3);
    wr(`SCIMS_MODE_IDX, 32'h3);
    wr(`SCIMS_IMASK_IDX, 32'h3f);
    wr(`SCIMS_CTRL2_IDX, 32'h1);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_start_send;
    int k;
    k = n_irq;
    seg(4'h4, 6'h01);
    chk("start irq", 32'h1, {31'h0, n_irq != k});
    wr(`SCIMS_DATA_IDX, 32'ha4);
    seg(4'h2, 6'h02);
    chk("sent byte", 32'ha4, {24'h0, got});
    chk("scl high", 32'h1, {31'h0, hi_ns inside {[126:210]}});
    wr(`SCIMS_DATA_IDX, 32'hf6);
    seg(4'h2, 6'h02);
    chk("ten-bit head", 32'hf6, {24'h0, got});
    wr(`SCIMS_DATA_IDX, 32'h5a);
    seg(4'h2, 6'h02);
    chk("ten-bit low", 32'h5a, {24'h0, got});
    ack_en = 0;
    seg(4'h2, 6'h2a);
    $display("t_start_send done");
  endtask : t_start_send
  task automatic t_recv;
    rd = 1;
    rbyte = 8'h5c;
    seg(4'h1, 6'h04);
    chk("master ack", 32'h0, {31'h0, ackb});
    rbyte = 8'h33;
    wr(`SCIMS_CTRL2_IDX, 32'h0);
    seg(4'h1, 6'h14);
    chk("master nack", 32'h1, {31'h0, ackb});
    rdc("rx byte", `SCIMS_DATA_IDX, 32'hff, 32'h5c);
    rdc("rx full", `SCIMS_STAT_IDX, 32'h40, 32'h0);
    rd = 0;
    $display("t_recv done");
  endtask : t_recv
  task automatic t_stop;
    int k;
    k = n_irq;
    top_en <= 0;
    seg(4'h8, 6'h01);
    chk("masked irq", 32'h0, {31'h0, n_irq != k});
    top_en <= 1;
    wr(`SCIMS_IMASK_IDX, 32'h3e);
    seg(4'h8, 6'h01);
    chk("block mask", 32'h0, {31'h0, n_irq != k});
    wr(`SCIMS_IMASK_IDX, 32'h3f);
    $display("t_stop done");
  endtask : t_stop
  task automatic t_refuse;
    int k;
    k = edges;
    seg(4'h6, 6'h00);
    for (int m = 0; m < 3; m++) begin
      wr(`SCIMS_MODE_IDX, 32'(m));
      seg(4'h4, 6'h00);
    end
    chk("bus idle", 32'(k), 32'(edges));
    wr(`SCIMS_MODE_IDX, 32'h0);
    wr(`SCIMS_MODE_IDX, 32'h3);
    $display("t_refuse done");
  endtask : t_refuse
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1;
    t_regs();
    t_start_send();
    t_recv();
    t_stop();
    t_refuse();
    wrap_up();
  end
endmodule : scims_top_tb
